/* mfbc_top.sv */
// MAC frame path: transmit and receive FIFOs, framing, CRC-16 and cipher hand-off
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Length field gives payload up to 127
// - Preamble is four zero bytes
// - Delimiter byte 0xA7 follows preamble
// - Length excludes itself, includes two FCS
// - Transmit pulls exactly length bytes
// - FCS uses x16+x12+x5+1 after payload
// - Received bytes stored by hardware, popped
// - Receive buffer is 256-byte circular FIFO
// - Each received frame stored length first
// - Auto CRC checks receive, sets good flag
// - Interrupts on receive done, decrypt done
// - Decrypt rewrites frame length byte
// - Push port appends byte to FIFO
// - Transmit FIFO entries directly addressable
// - Encrypt rewrites frame length byte
// - Commands start transmit or cipher
// - Auto CRC appends transmit FCS
// - Interrupts on encrypt done, transmit done
// - AES-128 engine, two selectable keys
// - Nine-bit pointers, wrap bit in status
// - Standalone AES has own command
// - Full at 256, empty at zero, read-only
// - Clear bit reinitialises pointers and status
module mfbc_top #(
    parameter logic [6:0] PRE_BYTES = mfbc_pkg::PREAMBLE_BYTES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [mfbc_pkg::MFBC_AW-1:0] bus_addr,
    input wire logic [mfbc_pkg::MFBC_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [mfbc_pkg::MFBC_DW-1:0] bus_rdata,
    output logic [7:0] phy_tx_data,
    output logic phy_tx_valid,
    output logic phy_tx_last,
    input wire logic phy_tx_ready,
    input wire logic [7:0] phy_rx_data,
    input wire logic phy_rx_valid,
    input wire logic phy_rx_sof,
    output logic phy_irq,
    output logic aes_irq,
    output logic aes_start,
    output logic aes_sa_start,
    output logic aes_decrypt,
    output logic aes_key_sel,
    output logic [7:0] aes_base,
    output logic [7:0] aes_len,
    input wire logic aes_done,
    input wire logic [7:0] aes_new_len
);
    import mfbc_pkg::*;

    mfbc_state_t s;
    mfbc_state_t n;
    logic [8:0] tx_used;
    logic [8:0] rx_used;
    logic tx_full, tx_empty, rx_full, rx_empty, tx_free;
    logic [7:0] tx_head;

    assign tx_used = s.tx_wp - s.tx_rp;
    assign rx_used = s.rx_wp - s.rx_rp;
    assign tx_full = (tx_used == FIFO_FULL_USED);
    assign rx_full = (rx_used == FIFO_FULL_USED);
    assign tx_empty = (tx_used == 9'h000);
    assign rx_empty = (rx_used == 9'h000);
    assign tx_head = s.tx_mem[s.tx_rp[7:0]];
    // A byte slot is free when empty or being taken this cycle
    assign tx_free = !s.tx_valid || phy_tx_ready;

    always_comb begin
        logic [15:0] rx_crc_nx;
        logic rx_done;
        logic [6:0] len7;
        rx_crc_nx = s.rx_crc;
        rx_done = 1'h0;
        len7 = 7'h00;
        n = s;
        n.aes_start = 1'h0;
        n.aes_sa_start = 1'h0;
        n.phy_irq = 1'h0;
        n.aes_irq = 1'h0;
        n.rdata = 8'h00;

        // Transmit framer; stalls on an empty FIFO rather than sending stale bytes
        if (s.tx_valid && phy_tx_ready) begin
            n.tx_valid = 1'h0;
        end
        if (tx_free) begin
            case (s.tx_st)
                TX_IDLE: begin
                end
                TX_PRE: begin
                    n.tx_data = PREAMBLE_BYTE;
                    n.tx_valid = 1'h1;
                    n.pre_seen = s.pre_seen + 7'h01;
                    n.tx_cnt = s.tx_cnt - 7'h01;
                    if (s.tx_cnt == 7'h01) begin
                        n.tx_st = TX_SFD;
                    end
                end
                TX_SFD: begin
                    n.tx_data = SFD_BYTE;
                    n.tx_valid = 1'h1;
                    n.tx_st = TX_LEN;
                end
                TX_LEN: begin
                    if (!tx_empty) begin
                        len7 = tx_head[6:0] & LEN_MASK[6:0];
                        n.tx_data = tx_head;
                        n.tx_valid = 1'h1;
                        n.tx_rp = s.tx_rp + 9'h001;
                        n.tx_cnt = len7;
                        n.tx_len = len7;
                        n.pulled = 7'h00;
                        n.tx_crc = CRC_INIT;
                        n.tx_last = (len7 == 7'h00);
                        if (s.tx_asa) begin
                            n.tx_sbase = s.tx_rp[7:0];
                            n.tx_slen = {1'h0, len7};
                        end
                        n.tx_st = (len7 == 7'h00) ? TX_DONE : TX_BODY;
                    end
                end
                TX_BODY: begin
                    if (!tx_empty) begin
                        n.tx_rp = s.tx_rp + 9'h001;
                        n.pulled = s.pulled + 7'h01;
                        n.tx_valid = 1'h1;
                        n.tx_data = tx_head;
                        if (s.tx_cnt > 7'h02) begin
                            n.tx_crc = mfbc_crc_byte(s.tx_crc, tx_head);
                        end else if (s.auto_crc && s.tx_cnt == 7'h02) begin
                            n.tx_data = s.tx_crc[7:0];
                        end else if (s.auto_crc) begin
                            n.tx_data = s.tx_crc[15:8];
                        end
                        n.tx_cnt = s.tx_cnt - 7'h01;
                        n.tx_last = (s.tx_cnt == 7'h01);
                        if (s.tx_cnt == 7'h01) begin
                            n.tx_st = TX_DONE;
                        end
                    end
                end
                TX_DONE: begin
                    n.tx_st = TX_IDLE;
                    n.tx_last = 1'h0;
                    n.phy_irq = 1'h1;
                end
                default: n.tx_st = TX_IDLE;
            endcase
        end

        // Receive path writes straight into the FIFO; bytes that find it full are lost
        if (phy_rx_valid && (s.rx_busy || phy_rx_sof)) begin
            if (s.rx_ena && !rx_full) begin
                n.rx_mem[s.rx_wp[7:0]] = phy_rx_data;
                n.rx_wp = s.rx_wp + 9'h001;
            end
            if (!s.rx_busy) begin
                len7 = phy_rx_data[6:0] & LEN_MASK[6:0];
                n.rx_start = s.rx_wp[7:0];
                n.rx_len = len7;
                n.rx_cnt = len7;
                n.rx_crc = CRC_INIT;
                rx_crc_nx = CRC_INIT;
                n.crc_ok = 1'h0;
                n.rx_busy = (len7 != 7'h00);
                rx_done = (len7 == 7'h00);
            end else begin
                rx_crc_nx = mfbc_crc_byte(s.rx_crc, phy_rx_data);
                n.rx_crc = rx_crc_nx;
                n.rx_cnt = s.rx_cnt - 7'h01;
                rx_done = (s.rx_cnt == 7'h01);
            end
        end
        if (rx_done) begin
            n.rx_busy = 1'h0;
            n.phy_irq = 1'h1;
            n.crc_ok = s.auto_crc && (rx_crc_nx == CRC_RESIDUE);
            if (s.rx_asa) begin
                n.rx_sbase = n.rx_start;
                n.rx_slen = {1'h0, n.rx_len};
            end
        end

        // Cipher completion: unless the run was standalone, new length replaces the frame's length byte in place
        if (s.aes_busy && aes_done) begin
            n.aes_busy = 1'h0;
            n.aes_irq = 1'h1;
            if (!s.aes_sa && s.aes_dec) begin
                n.rx_mem[s.aes_base] = aes_new_len;
            end else if (!s.aes_sa) begin
                n.tx_mem[s.aes_base] = aes_new_len;
            end
        end

        // Register writes take precedence over hardware pointer moves
        if (bus_wr) begin
            if (bus_addr[15:8] == TX_WINDOW_PAGE) begin
                n.tx_mem[bus_addr[7:0]] = bus_wdata;
            end else begin
                case (bus_addr)
                    TX_FIFO_PUSH_PORT: begin
                        if (s.tx_ena && !tx_full) begin
                            n.tx_mem[s.tx_wp[7:0]] = bus_wdata;
                            n.tx_wp = s.tx_wp + 9'h001;
                        end
                    end
                    TX_FIFO_WRITE_POINTER: n.tx_wp[7:0] = bus_wdata;
                    TX_FIFO_READ_POINTER: n.tx_rp[7:0] = bus_wdata;
                    TX_FIFO_CONTROL: begin
                        n.tx_ena = bus_wdata[CTL_ENA];
                        n.tx_asa = bus_wdata[CTL_ASA];
                        if (bus_wdata[CTL_CLR]) begin
                            n.tx_wp = 9'h000;
                            n.tx_rp = 9'h000;
                        end
                    end
                    TX_FIFO_STATUS: begin
                        n.tx_wp[8] = bus_wdata[STS_WP8];
                        n.tx_rp[8] = bus_wdata[STS_RP8];
                    end
                    TX_AES_BASE: n.tx_sbase = bus_wdata;
                    TX_AES_LENGTH: n.tx_slen = bus_wdata;
                    RX_FIFO_WRITE_POINTER: n.rx_wp[7:0] = bus_wdata;
                    RX_FIFO_READ_POINTER: n.rx_rp[7:0] = bus_wdata;
                    RX_FIFO_CONTROL: begin
                        n.rx_ena = bus_wdata[CTL_ENA];
                        n.rx_asa = bus_wdata[CTL_ASA];
                        if (bus_wdata[CTL_CLR]) begin
                            n.rx_wp = 9'h000;
                            n.rx_rp = 9'h000;
                        end
                    end
                    RX_FIFO_STATUS: begin
                        n.rx_wp[8] = bus_wdata[STS_WP8];
                        n.rx_rp[8] = bus_wdata[STS_RP8];
                    end
                    RX_AES_BASE: n.rx_sbase = bus_wdata;
                    RX_AES_LENGTH: n.rx_slen = bus_wdata;
                    MAC_CONTROL: begin
                        n.auto_crc = bus_wdata[MCT_AUTO_CRC];
                        n.key_sel = bus_wdata[MCT_KEY_SEL];
                    end
                    PHY_TRANSMIT_COMMAND: begin
                        if (s.tx_st == TX_IDLE) begin
                            n.tx_st = TX_PRE;
                            n.tx_cnt = PRE_BYTES;
                            n.pre_seen = 7'h00;
                        end
                    end
                    SECURITY_COMMAND: begin
                        if (!s.aes_busy) begin
                            n.aes_busy = 1'h1;
                            n.aes_sa = 1'h0;
                            n.aes_start = 1'h1;
                            n.aes_dec = bus_wdata[SEC_DECRYPT];
                            n.aes_base = bus_wdata[SEC_DECRYPT] ? s.rx_sbase : s.tx_sbase;
                            n.aes_len = bus_wdata[SEC_DECRYPT] ? s.rx_slen : s.tx_slen;
                        end
                    end
                    STANDALONE_AES_COMMAND: begin
                        if (!s.aes_busy) begin
                            n.aes_busy = 1'h1;
                            n.aes_sa = 1'h1;
                            n.aes_sa_start = 1'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Register reads; pop is the only read with a side effect
        if (bus_rd) begin
            if (bus_addr[15:8] == TX_WINDOW_PAGE) begin
                n.rdata = s.tx_mem[bus_addr[7:0]];
            end else begin
                case (bus_addr)
                    TX_FIFO_WRITE_POINTER: n.rdata = s.tx_wp[7:0];
                    TX_FIFO_READ_POINTER: n.rdata = s.tx_rp[7:0];
                    TX_FIFO_CONTROL: n.rdata = {5'h00, s.tx_asa, s.tx_ena, 1'h0};
                    TX_FIFO_STATUS: n.rdata = {s.tx_wp[8], s.tx_rp[8], 4'h0, tx_full, tx_empty};
                    TX_FIFO_SIZE: n.rdata = tx_used[7:0];
                    TX_AES_BASE: n.rdata = s.tx_sbase;
                    TX_AES_LENGTH: n.rdata = s.tx_slen;
                    RX_FIFO_POP_PORT: begin
                        if (!rx_empty) begin
                            n.rdata = s.rx_mem[s.rx_rp[7:0]];
                            n.rx_rp = s.rx_rp + 9'h001;
                        end
                    end
                    RX_FIFO_WRITE_POINTER: n.rdata = s.rx_wp[7:0];
                    RX_FIFO_READ_POINTER: n.rdata = s.rx_rp[7:0];
                    RX_FIFO_CONTROL: n.rdata = {5'h00, s.rx_asa, s.rx_ena, 1'h0};
                    RX_FIFO_STATUS: n.rdata = {s.rx_wp[8], s.rx_rp[8], 4'h0, rx_full, rx_empty};
                    RX_FIFO_SIZE: n.rdata = rx_used[7:0];
                    RX_AES_BASE: n.rdata = s.rx_sbase;
                    RX_AES_LENGTH: n.rdata = s.rx_slen;
                    MAC_CONTROL: n.rdata = {6'h00, s.key_sel, s.auto_crc};
                    MAC_STATUS: begin
                        n.rdata = {4'h0, s.aes_busy, s.rx_busy, (s.tx_st != TX_IDLE), s.crc_ok};
                    end
                    default: n.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.tx_ena <= CTL_RST[CTL_ENA];
            s.tx_asa <= CTL_RST[CTL_ASA];
            s.rx_ena <= CTL_RST[CTL_ENA];
            s.rx_asa <= CTL_RST[CTL_ASA];
            s.auto_crc <= MCT_RST[MCT_AUTO_CRC];
            s.key_sel <= MCT_RST[MCT_KEY_SEL];
        end else begin
            s <= n;
        end
    end

    assign bus_rdata = s.rdata;
    assign phy_tx_data = s.tx_data;
    assign phy_tx_valid = s.tx_valid;
    assign phy_tx_last = s.tx_last;
    assign phy_irq = s.phy_irq;
    assign aes_irq = s.aes_irq;
    assign aes_start = s.aes_start;
    assign aes_sa_start = s.aes_sa_start;
    assign aes_decrypt = s.aes_dec;
    assign aes_key_sel = s.key_sel;
    assign aes_base = s.aes_base;
    assign aes_len = s.aes_len;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_tx_cmd;
        bus_wr && bus_addr == PHY_TRANSMIT_COMMAND && s.tx_st == TX_IDLE;
    endsequence
    sequence seq_pre_start;
        s.tx_st == TX_PRE ##1 (phy_tx_valid && phy_tx_data == PREAMBLE_BYTE);
    endsequence
    sequence seq_tx_finish;
        s.tx_st == TX_DONE && tx_free;
    endsequence

    chk_tx_start_pre: assert property (seq_tx_cmd |=> seq_pre_start)
        else $error("transmit command did not start preamble");
    chk_preamble_count: assert property (s.tx_st == TX_SFD && tx_free |-> s.pre_seen == 7'h04)
        else $error("preamble byte count wrong before delimiter");
    chk_sfd_value: assert property (s.tx_st == TX_SFD && tx_free |=> phy_tx_valid && phy_tx_data == 8'hA7)
        else $error("delimiter byte not sent after preamble");
    chk_pull_count: assert property (seq_tx_finish |-> s.pulled == s.tx_len)
        else $error("bytes pulled differ from frame length");
    chk_tx_done_irq: assert property (seq_tx_finish |=> phy_irq && s.tx_st == TX_IDLE)
        else $error("transmit end gave no interrupt");
    chk_push_append: assert property (bus_wr && bus_addr == TX_FIFO_PUSH_PORT && s.tx_ena && !tx_full
        |=> s.tx_wp == $past(s.tx_wp) + 9'h001 && s.tx_mem[$past(s.tx_wp[7:0])] == $past(bus_wdata))
        else $error("push did not append byte");
    chk_full_status: assert property (bus_rd && bus_addr == TX_FIFO_STATUS
        |=> bus_rdata[STS_FULL] == $past(tx_full) && bus_rdata[STS_EMPTY] == $past(tx_empty))
        else $error("status flags disagree with fill");
    chk_fifo_clear: assert property (bus_wr && bus_addr == RX_FIFO_CONTROL && bus_wdata[CTL_CLR]
        |=> s.rx_wp == 9'h000 && s.rx_rp == 9'h000 && rx_empty)
        else $error("clear left receive pointers set");
    chk_rx_store: assert property (phy_rx_valid && (s.rx_busy || phy_rx_sof) && s.rx_ena && !rx_full
        |=> s.rx_wp == $past(s.rx_wp) + 9'h001 && s.rx_mem[$past(s.rx_wp[7:0])] == $past(phy_rx_data))
        else $error("received byte not stored");
    chk_rx_len_first: assert property (phy_rx_valid && !s.rx_busy && phy_rx_sof && s.rx_ena && !rx_full
        |=> s.rx_mem[s.rx_start] == $past(phy_rx_data))
        else $error("frame start does not hold length byte");
    chk_crc_ok_auto: assert property ($rose(s.crc_ok) |-> $past(s.auto_crc) && phy_irq)
        else $error("good CRC flag without automatic check");
    chk_len_rewrite: assert property (s.aes_busy && aes_done && !s.aes_sa
        |=> aes_irq && (s.aes_dec ? s.rx_mem[s.aes_base] : s.tx_mem[s.aes_base]) == $past(aes_new_len))
        else $error("cipher end did not rewrite length");
endmodule : mfbc_top
`default_nettype wire

/* mfbc_pkg.sv */
// Package: register map, field layout, reset values, frame constants and state of the MAC frame path
`default_nettype none
package mfbc_pkg;
    localparam int MFBC_AW = 16;
    localparam int MFBC_DW = 8;
    localparam int FIFO_DEPTH = 256;
    localparam logic [8:0] FIFO_FULL_USED = 9'h100;
    // Register offsets, byte addresses on the register port
    localparam logic [15:0] TX_FIFO_PUSH_PORT = 16'h2000;
    localparam logic [15:0] TX_FIFO_WRITE_POINTER = 16'h2001;
    localparam logic [15:0] TX_FIFO_READ_POINTER = 16'h2002;
    localparam logic [15:0] TX_FIFO_CONTROL = 16'h2003;
    localparam logic [15:0] TX_FIFO_STATUS = 16'h2004;
    localparam logic [15:0] TX_FIFO_SIZE = 16'h2005;
    localparam logic [15:0] TX_AES_BASE = 16'h2007;
    localparam logic [15:0] TX_AES_LENGTH = 16'h2008;
    localparam logic [15:0] RX_FIFO_POP_PORT = 16'h2080;
    localparam logic [15:0] RX_FIFO_WRITE_POINTER = 16'h2081;
    localparam logic [15:0] RX_FIFO_READ_POINTER = 16'h2082;
    localparam logic [15:0] RX_FIFO_CONTROL = 16'h2083;
    localparam logic [15:0] RX_FIFO_STATUS = 16'h2084;
    localparam logic [15:0] RX_FIFO_SIZE = 16'h2085;
    localparam logic [15:0] RX_AES_BASE = 16'h2087;
    localparam logic [15:0] RX_AES_LENGTH = 16'h2088;
    localparam logic [15:0] MAC_STATUS = 16'h2180;
    localparam logic [15:0] STANDALONE_AES_COMMAND = 16'h218E;
    localparam logic [15:0] MAC_CONTROL = 16'h2191;
    localparam logic [15:0] PHY_TRANSMIT_COMMAND = 16'h2200;
    localparam logic [15:0] SECURITY_COMMAND = 16'h2201;
    localparam logic [7:0] TX_WINDOW_PAGE = 8'h23;
    // Field positions
    localparam int CTL_CLR = 0;
    localparam int CTL_ENA = 1;
    localparam int CTL_ASA = 2;
    localparam int STS_EMPTY = 0;
    localparam int STS_FULL = 1;
    localparam int STS_RP8 = 6;
    localparam int STS_WP8 = 7;
    localparam int MCT_AUTO_CRC = 0;
    localparam int MCT_KEY_SEL = 1;
    localparam int SEC_DECRYPT = 0;
    // Reset values
    localparam logic [7:0] CTL_RST = 8'h06;
    localparam logic [7:0] MCT_RST = 8'h00;
    // Frame constants
    localparam int PREAMBLE_SYMBOLS = 8;
    localparam logic [6:0] PREAMBLE_BYTES = 7'(PREAMBLE_SYMBOLS / 2);
    localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
    localparam logic [7:0] SFD_BYTE = 8'hA7;
    localparam logic [7:0] LEN_MASK = 8'h7F;
    // x16 + x12 + x5 + 1, bit-reversed for LSB-first shifting
    localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_BODY, TX_DONE} mfbc_tx_st_t;

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][7:0] tx_mem;
        logic [FIFO_DEPTH-1:0][7:0] rx_mem;
        logic [8:0] tx_wp, tx_rp, rx_wp, rx_rp;
        logic tx_ena, tx_asa, rx_ena, rx_asa, auto_crc, key_sel, crc_ok;
        logic [7:0] tx_sbase, tx_slen, rx_sbase, rx_slen;
        mfbc_tx_st_t tx_st;
        logic [6:0] tx_cnt, tx_len, pulled, pre_seen;
        logic [15:0] tx_crc, rx_crc;
        logic [7:0] tx_data;
        logic tx_valid, tx_last, rx_busy;
        logic [6:0] rx_cnt, rx_len;
        logic [7:0] rx_start, aes_base, aes_len, rdata;
        logic aes_busy, aes_sa, aes_dec, aes_start, aes_sa_start, phy_irq, aes_irq;
    } mfbc_state_t;

    function automatic logic [15:0] mfbc_crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        logic fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ d[i];
            c = {1'h0, c[15:1]};
            if (fb) begin
                c = c ^ CRC_POLY_REFL;
            end
        end
        return c;
    endfunction : mfbc_crc_byte
endpackage : mfbc_pkg
`default_nettype wire

/* mfbc_phy_model.sv */
// Stand-in for the modem transmit sink and the cipher engine
`timescale 1ns/100ps
`default_nettype none
module mfbc_phy_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] phy_tx_data,
    input wire logic phy_tx_valid,
    output logic phy_tx_ready,
    input wire logic aes_start,
    output logic aes_done,
    output logic [7:0] aes_new_len
);
    logic [7:0] got[$];
    int wait_cnt;
    // Ready toggles so every byte after the first must be held across a stall
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_tx_ready <= 1'b0;
            aes_done <= 1'b0;
            aes_new_len <= 8'h5A;
            wait_cnt <= 0;
        end else begin
            phy_tx_ready <= ~phy_tx_ready;
            if (phy_tx_valid && phy_tx_ready) begin
                got.push_back(phy_tx_data);
            end
            aes_done <= (wait_cnt == 1);
            // Length is only meaningful beside done; otherwise it churns
            aes_new_len <= (wait_cnt == 1) ? 8'h09 : ~aes_new_len;
            if (aes_start) begin
                wait_cnt <= 6;
            end else if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule : mfbc_phy_model
`default_nettype wire

/* tb.sv */
// Register-level regression of the MAC frame path
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mfbc_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, rx_d = 8'h00, bus_rdata, txd, nlen, base, alen;
    logic rx_v = 1'b0, rx_sof = 1'b0, txv, txl, rdy, pirq, airq, ast, sast, adec, ksel, adone;
    int num_errors = 0, num_checks = 0, n_phy = 0, n_aes = 0, n_sa = 0, n_last = 0, cyc = 0, i;
    logic [15:0] c;
    logic [7:0] exp_tx[$];
    always #10 core_clk = ~core_clk;
    mfbc_top dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .phy_tx_data(txd), .phy_tx_valid(txv), .phy_tx_last(txl), .phy_tx_ready(rdy),
        .phy_rx_data(rx_d), .phy_rx_valid(rx_v), .phy_rx_sof(rx_sof), .phy_irq(pirq),
        .aes_irq(airq), .aes_start(ast), .aes_sa_start(sast), .aes_decrypt(adec),
        .aes_key_sel(ksel), .aes_base(base), .aes_len(alen), .aes_done(adone),
        .aes_new_len(nlen));
    mfbc_phy_model phy (.core_clk(core_clk), .rst_n(rst_n), .phy_tx_data(txd),
        .phy_tx_valid(txv), .phy_tx_ready(rdy), .aes_start(ast | sast), .aes_done(adone),
        .aes_new_len(nlen));
    always @(posedge core_clk) begin
        cyc++;
        n_phy += (pirq === 1'b1);
        n_aes += (airq === 1'b1);
        n_sa += (sast === 1'b1);
        n_last += (txl === 1'b1 && txv === 1'b1 && rdy === 1'b1);
        if (cyc == 6000) begin
            num_errors++;
            end_sim();
        end
    end
    // Reflected CRC-16 kept apart from the design's own helper
    function automatic logic [15:0] crc(input logic [15:0] r, input logic [7:0] d);
        for (int k = 0; k < 8; k++) begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
        end
        return r;
    endfunction : crc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask : rc
    task automatic rx(input logic [7:0] d, input logic s);
        @(posedge core_clk);
        rx_v <= 1'b1;
        rx_d <= d;
        rx_sof <= s;
    endtask : rx
    // Counters are read live; a copied-in argument would never see them move
    task automatic wait_irq(input bit sel, input int t);
        for (int k = 0; k < 300 && (sel ? n_aes : n_phy) < t; k++) @(posedge core_clk);
        chk(8'(sel ? n_aes : n_phy), 8'(t));
    endtask : wait_irq
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rc(TX_FIFO_CONTROL, 8'h06);
        rc(TX_FIFO_STATUS, 8'h01);
        rc(16'h2010, 8'h00);
        wr(MAC_CONTROL, 8'h01);
        c = crc(crc(crc(16'h0000, 8'hA1), 8'hA2), 8'hA3);
        exp_tx = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h05, 8'hA1, 8'hA2, 8'hA3, c[7:0], c[15:8]};
        foreach (exp_tx[k]) if (k > 4) wr(TX_FIFO_PUSH_PORT, (k > 8) ? 8'h00 : exp_tx[k]);
        rc(TX_FIFO_SIZE, 8'h06);
        wr(PHY_TRANSMIT_COMMAND, 8'h00);
        wait_irq(1'b0, 1);
        chk(8'(phy.got.size()), 8'h0B);
        chk(8'(n_last), 8'h01);
        foreach (exp_tx[k]) chk(phy.got[k], exp_tx[k]);
        rc(TX_FIFO_READ_POINTER, 8'h06);
        $display("-- transmit finished");
        c = crc(crc(crc(16'h0000, 8'hB1), 8'hB2), 8'hB3);
        exp_tx = '{8'h05, 8'hB1, 8'hB2, 8'hB3, c[7:0], c[15:8]};
        foreach (exp_tx[k]) rx(exp_tx[k], k == 0);
        @(posedge core_clk);
        rx_v <= 1'b0;
        wait_irq(1'b0, 2);
        rc(MAC_STATUS, 8'h01);
        foreach (exp_tx[k]) rc(RX_FIFO_POP_PORT, exp_tx[k]);
        rc(RX_FIFO_STATUS, 8'h01);
        $display("-- receive finished");
        wr(SECURITY_COMMAND, 8'h00);
        wait_irq(1'b1, 1);
        chk(base, 8'h00);
        rc(16'h2300, 8'h09);
        $display("-- cipher finished");
        wr(STANDALONE_AES_COMMAND, 8'h00);
        wait_irq(1'b1, 2);
        chk(8'(n_sa), 8'h01);
        rc(16'h2300, 8'h09);
        // Software-made CRC with the automatic check off, second key chosen
        wr(MAC_CONTROL, 8'h02);
        foreach (exp_tx[k]) rx(exp_tx[k], k == 0);
        @(posedge core_clk);
        rx_v <= 1'b0;
        wait_irq(1'b0, 3);
        chk({7'h00, ksel}, 8'h01);
        rc(MAC_STATUS, 8'h00);
        wr(SECURITY_COMMAND, 8'h01);
        wait_irq(1'b1, 3);
        chk({7'h00, adec}, 8'h01);
        chk(base, 8'h06);
        chk(alen, 8'h05);
        rc(RX_FIFO_POP_PORT, 8'h09);
        wr(RX_FIFO_CONTROL, 8'h07);
        rc(RX_FIFO_STATUS, 8'h01);
        $display("-- decrypt finished");
        wr(TX_FIFO_CONTROL, 8'h07);
        rc(TX_FIFO_WRITE_POINTER, 8'h00);
        for (i = 0; i < 257; i++) wr(TX_FIFO_PUSH_PORT, 8'(i));
        rc(TX_FIFO_STATUS, 8'h82);
        rc(TX_FIFO_SIZE, 8'h00);
        rc(16'h23FF, 8'hFF);
        $display("-- full finished");
        end_sim();
    end
endmodule : tb
`default_nettype wire
